// ---- pkg/data_cell_tx_queue_map.vh ----
`ifndef DATA_CELL_TX_QUEUE_MAP_VH
`define DATA_CELL_TX_QUEUE_MAP_VH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define IDX_CELL_QUEUE_CONFIG        16'h1038
`define IDX_CELL_QUEUE_WRITE_POINTER 16'h103a
`define IDX_CELL_QUEUE_READ_POINTER  16'h103c
`define IDX_CELL_QUEUE_CONTROL       16'h103e
`define IDX_CELL_GAP_TIMEOUT         16'h1040
`define IDX_CELL_QUEUE_STATUS        16'h1042
`define IDX_EVENT_STATUS             16'h1050
`define IDX_EVENT_CLEAR              16'h1052
`define IDX_EVENT_ENABLE             16'h1054

// ****************************************
// field positions
// ****************************************
`define CTRL_QUEUE_ENABLE      0
`define CTRL_FREE_RUN          1
`define CTRL_EMPTY_REQ_ENABLE  2
`define STAT_BUFFER_EMPTY      0
`define EVT_CELL_SENT          0
`define EVT_BECAME_EMPTY       1

// ****************************************
// reset values
// ****************************************
`define RST_WRITE_POINTER 8'h00
`define RST_CONTROL       3'h0
`define RST_GAP           10'h001
`define RST_SIZE_CODE     2'h0
`define RST_EVENTS        2'h0

// ****************************************
// timing: one gap unit in master clock periods
// ****************************************
`define CELL_GAP_UNIT_CYCLES 65535

`endif

// ---- src/data_cell_tx_queue.v ----
`include "data_cell_tx_queue_map.vh"

module data_cell_tx_queue #(
  parameter P_GAP_UNIT_CYCLES = `CELL_GAP_UNIT_CYCLES
) (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  // avalon-mm slave
  input  wire [15:0] i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // cell sender
  input  wire        i_cbr_busy,
  input  wire        i_cell_ready,
  output wire        o_cell_valid,
  output reg  [6:0]  o_cell_index,
  // cpu requests
  output wire        o_service_req,
  output wire        o_irq
);

  // ****************************************
  // bus slave
  // ****************************************
  reg         ack_q;
  wire        req;
  wire        wr_go;
  reg  [7:0]  wp_q;
  reg  [2:0]  ctrl_q;
  reg  [9:0]  gap_q;
  reg  [1:0]  size_q;
  reg  [1:0]  evt_stat_q;
  reg  [1:0]  evt_en_q;
  reg         empty_q;
  wire [15:0] idx;

  function hit;
    input [15:0] a;
    input [15:0] i;
    begin
      hit = (a == i);
    end
  endfunction

  assign idx   = {2'b00, i_avs_address[15:2]};
  assign req   = i_avs_read | i_avs_write;
  assign wr_go = i_avs_write & ack_q;
  // one wait state: request seen, then answered
  assign o_avs_waitrequest = req & ~ack_q;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  reg [15:0] rd_d;
  always @* begin
    rd_d = 16'h0000;
    if (hit(idx, `IDX_CELL_QUEUE_CONFIG)) begin
      rd_d = {14'h0000, size_q};
    end else if (hit(idx, `IDX_CELL_QUEUE_WRITE_POINTER)) begin
      rd_d = {8'h00, wp_q};
    end else if (hit(idx, `IDX_CELL_QUEUE_READ_POINTER)) begin
      rd_d = {9'h000, o_cell_index};
    end else if (hit(idx, `IDX_CELL_QUEUE_CONTROL)) begin
      rd_d = {13'h0000, ctrl_q};
    end else if (hit(idx, `IDX_CELL_GAP_TIMEOUT)) begin
      rd_d = {6'h00, gap_q};
    end else if (hit(idx, `IDX_CELL_QUEUE_STATUS)) begin
      rd_d = {15'h0000, empty_q};
    end else if (hit(idx, `IDX_EVENT_STATUS)) begin
      rd_d = {14'h0000, evt_stat_q};
    end else if (hit(idx, `IDX_EVENT_ENABLE)) begin
      rd_d = {14'h0000, evt_en_q};
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_avs_read & ~ack_q) begin
      o_avs_readdata <= {16'h0000, rd_d};
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  wire be_lo;
  wire be_hi;
  assign be_lo = wr_go & i_avs_byteenable[0];
  assign be_hi = wr_go & i_avs_byteenable[1];

  reg  [7:0] wp_d;
  reg  [2:0] ctrl_d;
  reg  [9:0] gap_d;
  reg  [1:0] size_d;
  reg  [1:0] evt_en_d;

  // read-only and unmapped indices fall through untouched
  always @* begin
    wp_d     = wp_q;
    ctrl_d   = ctrl_q;
    gap_d    = gap_q;
    size_d   = size_q;
    evt_en_d = evt_en_q;
    if (be_lo & hit(idx, `IDX_CELL_QUEUE_WRITE_POINTER)) begin
      wp_d = i_avs_writedata[7:0];
    end
    if (be_lo & hit(idx, `IDX_CELL_QUEUE_CONTROL)) begin
      ctrl_d = i_avs_writedata[2:0];
    end
    if (be_lo & hit(idx, `IDX_CELL_QUEUE_CONFIG)) begin
      size_d = i_avs_writedata[1:0];
    end
    if (be_lo & hit(idx, `IDX_CELL_GAP_TIMEOUT)) begin
      gap_d[7:0] = i_avs_writedata[7:0];
    end
    if (be_hi & hit(idx, `IDX_CELL_GAP_TIMEOUT)) begin
      gap_d[9:8] = i_avs_writedata[9:8];
    end
    if (be_lo & hit(idx, `IDX_EVENT_ENABLE)) begin
      evt_en_d = i_avs_writedata[1:0];
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q     <= `RST_WRITE_POINTER;
      ctrl_q   <= `RST_CONTROL;
      gap_q    <= `RST_GAP;
      size_q   <= `RST_SIZE_CODE;
      evt_en_q <= `RST_EVENTS;
    end else begin
      wp_q     <= wp_d;
      ctrl_q   <= ctrl_d;
      gap_q    <= gap_d;
      size_q   <= size_d;
      evt_en_q <= evt_en_d;
    end
  end

  wire queue_enable;
  wire free_run;
  wire empty_request_enable;
  assign queue_enable         = ctrl_q[`CTRL_QUEUE_ENABLE];
  assign free_run             = ctrl_q[`CTRL_FREE_RUN];
  assign empty_request_enable = ctrl_q[`CTRL_EMPTY_REQ_ENABLE];

  // ****************************************
  // gap timer
  // ****************************************
  reg  [15:0] unit_cnt_q;
  reg  [9:0]  gap_cnt_q;
  reg         gap_done_q;
  wire        unit_tick;
  wire        cell_sent;
  reg  [15:0] unit_cnt_d;
  reg  [9:0]  gap_cnt_d;
  reg         gap_done_d;
  localparam integer UNIT_LAST_INT = P_GAP_UNIT_CYCLES - 1;
  localparam [15:0]  UNIT_LAST     = UNIT_LAST_INT[15:0];

  assign unit_tick = (unit_cnt_q == UNIT_LAST);

  // timer restarts with every sent cell, so the gap is cell to cell
  always @* begin
    unit_cnt_d = unit_cnt_q;
    gap_cnt_d  = gap_cnt_q;
    gap_done_d = gap_done_q;
    if (cell_sent | ~queue_enable | free_run) begin
      unit_cnt_d = 16'h0000;
      gap_cnt_d  = 10'h000;
      gap_done_d = 1'b0;
    end else if (!gap_done_q) begin
      if (unit_tick) begin
        unit_cnt_d = 16'h0000;
        gap_cnt_d  = gap_cnt_q + 10'h001;
        if (gap_cnt_q + 10'h001 == gap_q) begin
          gap_done_d = 1'b1;
        end
      end else begin
        unit_cnt_d = unit_cnt_q + 16'h0001;
      end
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      unit_cnt_q <= 16'h0000;
      gap_cnt_q  <= 10'h000;
      gap_done_q <= 1'b0;
    end else begin
      unit_cnt_q <= unit_cnt_d;
      gap_cnt_q  <= gap_cnt_d;
      gap_done_q <= gap_done_d;
    end
  end

  // ****************************************
  // send pointer and cell handshake
  // ****************************************
  wire       pending;
  wire       pace_ok;
  reg  [6:0] wrap_mask;

  always @* begin
    case (size_q)
      2'h0:    wrap_mask = 7'h0f;
      2'h1:    wrap_mask = 7'h1f;
      2'h2:    wrap_mask = 7'h3f;
      default: wrap_mask = 7'h7f;
    endcase
  end

  // the cell under the write pointer is still being filled
  assign pending = ({1'b0, o_cell_index} != wp_q);
  assign pace_ok = free_run ? ~i_cbr_busy
                            : (gap_done_q & (gap_q != 10'h000));
  assign o_cell_valid = queue_enable & pending & pace_ok;
  assign cell_sent    = o_cell_valid & i_cell_ready;

  reg  [6:0] idx_d;

  always @* begin
    idx_d = o_cell_index;
    if (!queue_enable) begin
      idx_d = 7'h00;
    end else if (cell_sent) begin
      idx_d = (o_cell_index + 7'h01) & wrap_mask;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cell_index <= 7'h00;
    end else begin
      o_cell_index <= idx_d;
    end
  end

  // ****************************************
  // empty flag and service request
  // ****************************************
  wire empty_d;
  assign empty_d = queue_enable & ~pending;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      empty_q <= 1'b0;
    end else begin
      empty_q <= empty_d;
    end
  end

  assign o_service_req = empty_q & empty_request_enable;

  // ****************************************
  // event interrupts
  // ****************************************
  wire [1:0] evt_set;
  wire [1:0] evt_clr;
  assign evt_set = {empty_d & ~empty_q, cell_sent};
  assign evt_clr = (be_lo & hit(idx, `IDX_EVENT_CLEAR))
                   ? i_avs_writedata[1:0] : 2'b00;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_evt
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          evt_stat_q[g] <= 1'b0;
        end else if (evt_set[g]) begin
          evt_stat_q[g] <= 1'b1;
        end else if (evt_clr[g]) begin
          evt_stat_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign o_irq = |(evt_stat_q & evt_en_q);

endmodule

// ---- testbench/cell_sink.sv ----
module cell_sink (
  // clock and reset
  input  logic i_clk,
  input  logic i_rst_n,
  // pacing and cell link
  input  logic i_slow,
  input  logic i_valid,
  output logic o_ready,
  output int   o_count
);
  timeunit 1ns;
  timeprecision 100ps;
  // slow mode drops ready every other cycle
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
      o_count <= 0;
    end else begin
      o_ready <= i_slow ? !o_ready : 1'b1;
      if (i_valid && o_ready) o_count <= o_count + 1;
    end
  end
endmodule

// ---- testbench/data_cell_tx_queue_asserts.sv ----
module data_cell_tx_queue_asserts (
  // clock and reset
  input logic        i_clk,
  input logic        i_rst_n,
  // register bus
  input logic [15:0] i_avs_address,
  input logic        i_avs_read,
  input logic        i_avs_write,
  input logic [31:0] i_avs_writedata,
  input logic [3:0]  i_avs_byteenable,
  input logic [31:0] o_avs_readdata,
  input logic        o_avs_waitrequest,
  // cell link and requests
  input logic        i_cbr_busy,
  input logic        i_cell_ready,
  input logic        o_cell_valid,
  input logic [6:0]  o_cell_index,
  input logic        o_service_req,
  input logic        o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_req_wait;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_send;
    o_cell_valid && i_cell_ready;
  endsequence
  chk_one_wait: assert property (s_req_wait |=> !o_avs_waitrequest)
    else $error("bus wait longer than one cycle");
  chk_idle_nowait: assert property (!(i_avs_read || i_avs_write)
    |-> !o_avs_waitrequest) else $error("wait with no request");
  chk_read_upper: assert property (i_avs_read && !o_avs_waitrequest
    |-> o_avs_readdata[31:16] == 16'h0) else $error("upper read bits");
  chk_read_stable: assert property (i_avs_read && !o_avs_waitrequest
    |=> $stable(o_avs_readdata)) else $error("read data moved");
  chk_index_step: assert property (s_send |=> o_cell_index == 7'h0 ||
    o_cell_index == $past(o_cell_index) + 7'h1) else $error("bad step");
  chk_index_hold: assert property (!(o_cell_valid && i_cell_ready) |=>
    $stable(o_cell_index) || o_cell_index == 7'h0) else $error("idx moved");
  chk_reset_quiet: assert property ($rose(i_rst_n) |->
    !o_cell_valid && o_cell_index == 7'h0) else $error("busy after reset");
  chk_valid_holds: assert property (o_cell_valid && !i_cell_ready &&
    !i_cbr_busy && !i_avs_write |=> o_cell_valid) else $error("valid lost");
endmodule
bind data_cell_tx_queue data_cell_tx_queue_asserts u_chk (.*);

// ---- testbench/tb_top.sv ----
`include "data_cell_tx_queue_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int UNIT = 4;
  localparam logic [15:0] WP = `IDX_CELL_QUEUE_WRITE_POINTER;
  localparam logic [15:0] RP = `IDX_CELL_QUEUE_READ_POINTER;
  localparam logic [15:0] CR = `IDX_CELL_QUEUE_CONTROL;
  localparam logic [15:0] GT = `IDX_CELL_GAP_TIMEOUT;
  localparam logic [15:0] ST = `IDX_CELL_QUEUE_STATUS;
  logic        clk, rst_n, rd, wr, busy, slow, wreq, ready, valid, sreq, irq;
  logic [15:0] addr, q;
  logic [31:0] wdata, rdata;
  logic [6:0]  idx;
  int          cnt, miscompares, total_checks;
  data_cell_tx_queue #(.P_GAP_UNIT_CYCLES(UNIT)) uut (
    .i_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_cbr_busy(busy),
    .i_cell_ready(ready), .o_cell_valid(valid), .o_cell_index(idx),
    .o_service_req(sreq), .o_irq(irq));
  cell_sink sink (.i_clk(clk), .i_rst_n(rst_n), .i_slow(slow),
    .i_valid(valid), .o_ready(ready), .o_count(cnt));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input bit w, input logic [15:0] i, input logic [15:0] d);
    int n;
    addr <= {i[13:0], 2'b00};
    rd <= !w;
    wr <= w;
    wdata <= {16'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (wreq !== 1'b0) begin
      miscompares++;
      tally_and_finish();
    end
    q = rdata[15:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [15:0] i, input logic [15:0] e);
    bus(0, i, 16'h0);
    chk(q, e);
  endtask
  task automatic wait_cnt(input int n);
    for (int k = 0; k < 2000 && cnt < n; k++) @(posedge clk);
    chk(16'(cnt), 16'(n));
    if (cnt < n) tally_and_finish();
  endtask
  task automatic t_regs();
    rc(WP, 16'h0000);
    rc(CR, 16'h0000);
    rc(GT, 16'h0001);
    rc(ST, 16'h0000);
    bus(1, RP, 16'h0055);
    rc(RP, 16'h0000);
    bus(1, 16'h1100, 16'hffff);
    rc(16'h1100, 16'h0000);
    bus(1, WP, 16'hffff);
    rc(WP, 16'h00ff);
    $display("regs test done");
  endtask
  task automatic t_free();
    bus(1, `IDX_EVENT_ENABLE, 16'h0001);
    bus(1, WP, 16'h0003);
    busy <= 1'b1;
    bus(1, CR, 16'h0007);
    repeat (8) @(posedge clk);
    chk(16'(cnt), 16'h0);
    busy <= 1'b0;
    wait_cnt(3);
    repeat (4) @(posedge clk);
    chk(16'(cnt), 16'h3);
    chk({9'h0, idx}, 16'h3);
    rc(RP, 16'h0003);
    rc(ST, 16'h0001);
    chk({15'h0, sreq}, 16'h1);
    chk({15'h0, irq}, 16'h1);
    rc(`IDX_EVENT_ENABLE, 16'h0001);
    rc(`IDX_EVENT_STATUS, 16'h0003);
    bus(1, `IDX_EVENT_CLEAR, 16'h0003);
    chk({15'h0, irq}, 16'h0);
    rc(`IDX_EVENT_STATUS, 16'h0000);
    bus(1, CR, 16'h0003);
    chk({15'h0, sreq}, 16'h0);
    bus(1, CR, 16'h0000);
    rc(RP, 16'h0000);
    rc(ST, 16'h0000);
    chk({15'h0, valid}, 16'h0);
    $display("free-run test done");
  endtask
  task automatic t_wrap();
    int b;
    b = cnt;
    slow <= 1'b1;
    bus(1, `IDX_CELL_QUEUE_CONFIG, 16'h0000);
    bus(1, WP, 16'h0005);
    bus(1, CR, 16'h0003);
    wait_cnt(b + 5);
    bus(1, WP, 16'h0000);
    wait_cnt(b + 16);
    repeat (6) @(posedge clk);
    chk(16'(cnt), 16'(b + 16));
    chk({9'h0, idx}, 16'h0);
    bus(1, CR, 16'h0000);
    bus(1, `IDX_CELL_QUEUE_CONFIG, 16'h0001);
    rc(`IDX_CELL_QUEUE_CONFIG, 16'h0001);
    bus(1, WP, 16'h0010);
    b = cnt;
    bus(1, CR, 16'h0003);
    wait_cnt(b + 16);
    repeat (6) @(posedge clk);
    chk(16'(cnt), 16'(b + 16));
    chk({9'h0, idx}, 16'h0010);
    bus(1, CR, 16'h0000);
    slow <= 1'b0;
    $display("wrap test done");
  endtask
  task automatic t_timer();
    int k, b, t1;
    bus(1, GT, 16'h0002);
    bus(1, WP, 16'h0002);
    bus(1, CR, 16'h0001);
    b = cnt;
    t1 = -1;
    for (k = 0; k < 400 && cnt < b + 2; k++) begin
      @(posedge clk);
      if (cnt == b + 1 && t1 < 0) t1 = k;
    end
    chk(16'(cnt), 16'(b + 2));
    chk(16'((k - t1) inside {[2 * UNIT:2 * UNIT + 3]}), 16'h1);
    bus(1, CR, 16'h0000);
    bus(1, GT, 16'h0000);
    bus(1, CR, 16'h0001);
    b = cnt;
    // long enough for the ten-bit gap count to wrap once
    repeat (1024 * UNIT + 40) @(posedge clk);
    chk(16'(cnt), 16'(b));
    $display("timer test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    {rd, wr, busy, slow, addr, wdata} = '0;
    miscompares = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_free();
    t_wrap();
    t_timer();
    tally_and_finish();
  end
endmodule
